// ---- hw/pim_top.sv ----
// per-port phy interrupt manager with its management interface slave
// How it works
// (R1) reset always leaves the block in primary interrupt mode
// (R2) primary mode: enabled flag assert raises line, deassert event drops it, except link down
// (R3) mask bits 30.9..30.1 gate flags 29.9..29.1, one per source
// (R4) seven flags set on source rise, clear on fall or flag read
// (R5) remote fault: rise sets; fall, basic status read or flag read clear
// (R6) link down: falling link status sets; only reg 1 or 29 read clears
// (R7) fault/page flags also clear on reg 6 read, restart or link loss
// (R8) link-up source is the internal link state, not a register bit
// (R9) wake event is the or of wakeup bits 7:4 anded with 3:0
// (R10) energy mask set, cleared while energy high: 256 ms pulse after loss
// (R11) software should clear the energy mask when servicing that event
// (R12) energy flag reads one after reset, then follows the source
// (R13) writing one to the alternate mode bit selects alternate mode
// (R14) alternate mode: software removes cause, then writes one to flag
// (R15) alternate write-one clears flag only if source is inactive
// (R16) alternate write-one with source still active leaves flag and line
// (R17) enabled flags are ored into one interrupt line for the system
// (R18) registers via two-wire management; unknown addresses read all ones
// (R19) alternate mode: reading the flag register clears nothing
`timescale 1ns/100ps
`default_nettype none
module pim_top #(
  parameter int ENERGY_DELAY_CYCLES = pim_pkg::ENERGY_DELAY_CYC,
  parameter int ENERGY_HOLD_CYCLES = pim_pkg::ENERGY_HOLD_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic mgmt_clk_in,
  input wire logic mgmt_data_in,
  output logic mgmt_data_out,
  output logic mgmt_data_oe_out,
  input wire logic [4:0] phy_addr_in,
  input wire logic internal_link_state_in,
  input wire logic [7:0] wakeup_control_status_in,
  input wire logic line_energy_present_in,
  input wire logic an_complete_in,
  input wire logic remote_fault_in,
  input wire logic link_status_in,
  input wire logic partner_ack_in,
  input wire logic par_detect_fault_in,
  input wire logic page_received_in,
  input wire logic an_restart_in,
  input wire logic ext_hit_in,
  input wire logic [15:0] ext_rdata_in,
  output pim_pkg::pim_acc_t ext_acc_out,
  output logic alternate_mode_select_out,
  output logic phy_irq_out
);
  // pin synchronisers: bit 0 is read only by bit 1
  logic [2:0] mdc_sync_r;
  logic [2:0] mdio_sync_r;
  logic mdc_lvl_r;
  logic mdio_lvl_r;
  wire mdc_agree = mdc_sync_r[1] == mdc_sync_r[2];
  wire mdc_rise = mdc_agree && mdc_sync_r[2] && !mdc_lvl_r;
  wire mdc_fall = mdc_agree && !mdc_sync_r[2] && mdc_lvl_r;
  wire mdio_bit = (mdio_sync_r[1] == mdio_sync_r[2]) ? mdio_sync_r[2]
                                                     : mdio_lvl_r;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mdc_sync_r <= 3'h0;
      mdio_sync_r <= 3'h7;
      mdc_lvl_r <= 1'b0;
      mdio_lvl_r <= 1'b1;
    end else begin
      mdc_sync_r <= {mdc_sync_r[1:0], mgmt_clk_in};
      mdio_sync_r <= {mdio_sync_r[1:0], mgmt_data_in};
      if (mdc_agree)
        mdc_lvl_r <= mdc_sync_r[2];
      mdio_lvl_r <= mdio_bit;
    end
  end

  // management frame slave
  pim_pkg::pim_smi_st_t smi_st_r;
  logic [5:0] ones_r;
  logic [4:0] cnt_r;
  logic [12:0] hdr_r;
  logic [15:0] sh_r;
  logic [4:0] reg_addr_r;
  logic rd_pulse_r;
  logic wr_pulse_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata;

  wire [12:0] hdr_full = {hdr_r[11:0], mdio_bit};
  wire hdr_done = smi_st_r == pim_pkg::SMI_HDR && cnt_r == 5'h00;
  wire hdr_st_ok = hdr_full[12];
  wire [1:0] hdr_op = hdr_full[11:10];
  wire hdr_match = hdr_st_ok && hdr_full[9:5] == phy_addr_in;
  wire hdr_read = hdr_match && hdr_op == pim_pkg::OP_READ;
  wire hdr_write = hdr_match && hdr_op == pim_pkg::OP_WRITE;
  wire [4:0] hdr_reg = hdr_full[4:0];
  wire cnt_zero = cnt_r == 5'h00;
  wire [4:0] cnt_dec = cnt_r - 5'h01;
  wire preamble_ok = ones_r >= pim_pkg::PREAMBLE_ONES;
  wire [5:0] ones_inc = preamble_ok ? ones_r : ones_r + 6'h01;
  // read strobe fires on the last header bit, data is captured in step
  wire rd_now = mdc_rise && hdr_done && hdr_read;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      smi_st_r <= pim_pkg::SMI_IDLE;
      ones_r <= 6'h00;
      cnt_r <= 5'h00;
      hdr_r <= 13'h0000;
      sh_r <= pim_pkg::ZERO16;
      reg_addr_r <= 5'h00;
      wr_pulse_r <= 1'b0;
      rd_pulse_r <= 1'b0;
      wdata_r <= pim_pkg::ZERO16;
    end else begin
      wr_pulse_r <= 1'b0;
      rd_pulse_r <= rd_now;
      if (mdc_rise) begin
        unique case (smi_st_r)
          pim_pkg::SMI_IDLE: begin
            // no preamble suppression: every frame needs 32 ones
            if (mdio_bit)
              ones_r <= ones_inc;
            else begin
              ones_r <= 6'h00;
              if (preamble_ok) begin
                smi_st_r <= pim_pkg::SMI_HDR;
                cnt_r <= pim_pkg::HDR_BITS_M1;
              end
            end
          end
          pim_pkg::SMI_HDR: begin
            hdr_r <= hdr_full;
            cnt_r <= cnt_dec;
            if (cnt_zero) begin
              reg_addr_r <= hdr_reg;
              cnt_r <= pim_pkg::TA_BITS_M1;
              sh_r <= rdata; // R18
              if (hdr_read)
                smi_st_r <= pim_pkg::SMI_RTA;
              else if (hdr_write)
                smi_st_r <= pim_pkg::SMI_WTA;
              else
                smi_st_r <= pim_pkg::SMI_IDLE;
            end
          end
          pim_pkg::SMI_RTA, pim_pkg::SMI_WTA: begin
            cnt_r <= cnt_dec;
            if (cnt_zero) begin
              cnt_r <= pim_pkg::DATA_BITS_M1;
              smi_st_r <= (smi_st_r == pim_pkg::SMI_RTA) ? pim_pkg::SMI_RD
                                                         : pim_pkg::SMI_WR;
            end
          end
          pim_pkg::SMI_RD: begin
            sh_r <= {sh_r[14:0], 1'b0};
            cnt_r <= cnt_dec;
            if (cnt_zero)
              smi_st_r <= pim_pkg::SMI_IDLE;
          end
          pim_pkg::SMI_WR: begin
            sh_r <= {sh_r[14:0], mdio_bit};
            cnt_r <= cnt_dec;
            if (cnt_zero) begin
              wdata_r <= {sh_r[14:0], mdio_bit};
              wr_pulse_r <= 1'b1;
              smi_st_r <= pim_pkg::SMI_IDLE;
            end
          end
          default: smi_st_r <= pim_pkg::SMI_IDLE;
        endcase
      end
    end
  end

  // pin drive changes on the falling clock so the master samples it stable
  wire drive_ta = smi_st_r == pim_pkg::SMI_RTA && cnt_zero;
  wire drive_rd = smi_st_r == pim_pkg::SMI_RD;
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      mgmt_data_out <= 1'b0;
      mgmt_data_oe_out <= 1'b0;
    end else if (mdc_fall) begin
      mgmt_data_oe_out <= drive_ta || drive_rd;
      mgmt_data_out <= drive_rd && sh_r[15];
    end
  end

  // event sources and flags
  logic [9:1] flag_r;
  logic [9:1] mask_r;
  logic [9:1] src_prev_r;
  logic alt_r;
  wire wake_event_signal = |(wakeup_control_status_in[7:4] &
                             wakeup_control_status_in[3:0]); // R9
  // R8: link-up follows the internal link state
  wire [9:1] src = {internal_link_state_in, wake_event_signal,
                    line_energy_present_in, an_complete_in, remote_fault_in,
                    link_status_in, partner_ack_in, par_detect_fault_in,
                    page_received_in}; // R3
  wire [9:1] rise = src & ~src_prev_r;
  wire [9:1] fall = ~src & src_prev_r;
  wire [9:1] set_ev = (rise & pim_pkg::RISE_SET_M) |
                      (fall & ~pim_pkg::RISE_SET_M); // R4 R5 R6
  wire link_loss = fall[pim_pkg::LINK_STATUS_IDX];
  wire rd_flag = rd_pulse_r && reg_addr_r == pim_pkg::REG_EVENT_FLAG;
  wire rd_basic = rd_pulse_r && reg_addr_r == pim_pkg::REG_BASIC_STATUS;
  wire rd_anexp = rd_pulse_r && reg_addr_r == pim_pkg::REG_AN_EXPANSION;
  wire wr_flag = wr_pulse_r && reg_addr_r == pim_pkg::REG_EVENT_FLAG;
  wire wr_mask = wr_pulse_r && reg_addr_r == pim_pkg::REG_EVENT_ENABLE_MASK;
  wire wr_mode = wr_pulse_r && reg_addr_r == pim_pkg::REG_MODE_CONTROL_STATUS;
  wire [9:1] wr_ones = wdata_r[pim_pkg::FLAG_MSB:pim_pkg::FLAG_LSB];
  wire [9:1] pri_clr = (fall & pim_pkg::FALL_CLR_M) |
                       {9{rd_flag}} |
                       ({9{rd_basic}} & pim_pkg::RD_BASIC_CLR_M) |
                       ({9{rd_anexp | an_restart_in | link_loss}} &
                        pim_pkg::RD_ANEXP_CLR_M); // R4 R5 R6 R7
  wire [9:1] inactive = (src & pim_pkg::IDLE_HIGH_M) |
                        (~src & ~pim_pkg::IDLE_HIGH_M);
  // R15 R16 R19: alternate clears only by checked write-one
  wire [9:1] alt_clr = {9{wr_flag}} & wr_ones & inactive;
  wire [9:1] clr = alt_r ? alt_clr : pri_clr;
  // an event in the clearing cycle wins
  wire [9:1] flag_nxt = set_ev | (flag_r & ~clr);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      flag_r <= pim_pkg::FLAG_RESET; // R12
      mask_r <= pim_pkg::MASK_RESET;
      src_prev_r <= pim_pkg::FLAG_RESET; // R12
      alt_r <= 1'b0; // R1
    end else begin
      flag_r <= flag_nxt; // R2
      src_prev_r <= src;
      if (wr_mask)
        mask_r <= wr_ones; // R3
      if (wr_mode)
        alt_r <= wdata_r[pim_pkg::ALT_MODE_BIT]; // R13
    end
  end

  // late energy pulse after cable removal
  pim_pkg::pim_en_st_t en_st_r;
  logic [pim_pkg::TMR_W-1:0] tmr_r;
  localparam int EI = pim_pkg::ENERGY_IDX;
  wire en_mask = mask_r[EI];
  wire en_cleared_high = flag_r[EI] && !flag_nxt[EI] &&
                         line_energy_present_in;
  wire tmr_done = tmr_r == '0;
  wire [pim_pkg::TMR_W-1:0] delay_ld =
    pim_pkg::TMR_W'(ENERGY_DELAY_CYCLES - 1);
  wire [pim_pkg::TMR_W-1:0] hold_ld = pim_pkg::TMR_W'(ENERGY_HOLD_CYCLES - 1);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      en_st_r <= pim_pkg::EN_IDLE;
      tmr_r <= '0;
    end else if (!en_mask) begin
      // clearing the mask cancels a pending pulse
      en_st_r <= pim_pkg::EN_IDLE; // R11
    end else begin
      tmr_r <= tmr_r - pim_pkg::TMR_W'(1);
      unique case (en_st_r)
        pim_pkg::EN_IDLE:
          if (en_cleared_high)
            en_st_r <= pim_pkg::EN_ARMED; // R10
        pim_pkg::EN_ARMED:
          if (fall[EI]) begin
            en_st_r <= pim_pkg::EN_WAIT;
            tmr_r <= delay_ld; // R10
          end
        pim_pkg::EN_WAIT:
          if (tmr_done) begin
            en_st_r <= pim_pkg::EN_HOLD;
            tmr_r <= hold_ld; // R10
          end
        pim_pkg::EN_HOLD:
          if (tmr_done)
            en_st_r <= pim_pkg::EN_IDLE;
      endcase
    end
  end

  // register read data
  always_comb begin
    rdata = pim_pkg::ZERO16;
    unique case (1'b1)
      hdr_reg == pim_pkg::REG_EVENT_FLAG:
        rdata[pim_pkg::FLAG_MSB:pim_pkg::FLAG_LSB] = flag_r;
      hdr_reg == pim_pkg::REG_EVENT_ENABLE_MASK:
        rdata[pim_pkg::FLAG_MSB:pim_pkg::FLAG_LSB] = mask_r;
      hdr_reg == pim_pkg::REG_MODE_CONTROL_STATUS: begin
        rdata[pim_pkg::ALT_MODE_BIT] = alt_r;
        rdata[pim_pkg::ENERGY_BIT] = line_energy_present_in;
      end
      default:
        rdata = ext_hit_in ? ext_rdata_in : pim_pkg::ALL_ONES; // R18
    endcase
  end

  // accesses to registers kept outside are passed on
  always_ff @(posedge sys_clk_in) begin
    if (srst_in)
      ext_acc_out <= '0;
    else begin
      ext_acc_out.addr <= reg_addr_r;
      ext_acc_out.rd <= rd_pulse_r && !(reg_addr_r == pim_pkg::REG_EVENT_FLAG ||
        reg_addr_r == pim_pkg::REG_EVENT_ENABLE_MASK ||
        reg_addr_r == pim_pkg::REG_MODE_CONTROL_STATUS);
      ext_acc_out.wr <= wr_pulse_r && !wr_flag && !wr_mask && !wr_mode;
      ext_acc_out.wdata <= wdata_r;
    end
  end

  assign alternate_mode_select_out = alt_r;
  // late energy pulse rides on the line regardless of the flag
  assign phy_irq_out = |(flag_r & mask_r) ||
                       (en_st_r == pim_pkg::EN_HOLD); // R17
endmodule
`default_nettype wire

// ---- hw/pim_pkg.sv ----
// shared constants and types for the phy interrupt manager
package pim_pkg;
  // register addresses on the management interface
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_MODE_CONTROL_STATUS = 5'h11;
  localparam logic [4:0] REG_EVENT_FLAG = 5'h1d;
  localparam logic [4:0] REG_EVENT_ENABLE_MASK = 5'h1e;
  // bit positions inside the mode control/status register
  localparam int ALT_MODE_BIT = 6;
  localparam int ENERGY_BIT = 1;
  // flag field sits in bits 9:1 of the flag and mask registers
  localparam int FLAG_LSB = 1;
  localparam int FLAG_MSB = 9;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // per-flag selections, bit 9 down to bit 1
  localparam logic [9:1] RISE_SET_M = 9'h1f7;
  localparam logic [9:1] FALL_CLR_M = 9'h1f7;
  localparam logic [9:1] RD_BASIC_CLR_M = 9'h018;
  localparam logic [9:1] RD_ANEXP_CLR_M = 9'h003;
  localparam logic [9:1] IDLE_HIGH_M = 9'h008;
  localparam logic [9:1] FLAG_RESET = 9'h040;
  localparam logic [9:1] MASK_RESET = 9'h000;
  localparam int ENERGY_IDX = 7;
  localparam int LINK_STATUS_IDX = 4;
  // management frame framing
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HDR_BITS_M1 = 5'h0c;
  localparam logic [4:0] TA_BITS_M1 = 5'h01;
  localparam logic [4:0] DATA_BITS_M1 = 5'h0f;
  // energy re-assert timing
  localparam int CLK_HZ = 25000000;
  localparam int ENERGY_DELAY_MS = 1000;
  localparam int ENERGY_HOLD_MS = 256;
  localparam int ENERGY_DELAY_CYC = (CLK_HZ / 1000) * ENERGY_DELAY_MS;
  localparam int ENERGY_HOLD_CYC = (CLK_HZ / 1000) * ENERGY_HOLD_MS;
  localparam int TMR_W = 25;

  // access seen on the management interface, for registers kept elsewhere
  typedef struct packed {
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } pim_acc_t;

  typedef enum logic [2:0] {
    SMI_IDLE, SMI_HDR, SMI_RTA, SMI_RD, SMI_WTA, SMI_WR
  } pim_smi_st_t;

  typedef enum logic [1:0] {
    EN_IDLE, EN_ARMED, EN_WAIT, EN_HOLD
  } pim_en_st_t;
endpackage

// ---- bench/pim_top_assertions.sv ----
// port checker for the interrupt manager
`timescale 1ns/100ps
`default_nettype none
module pim_top_checker #(
  parameter int ENERGY_DELAY_CYCLES = 50,
  parameter int ENERGY_HOLD_CYCLES = 20
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic mgmt_clk_in,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe_out,
  input wire pim_pkg::pim_acc_t ext_acc_out,
  input wire logic alternate_mode_select_out,
  input wire logic phy_irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  // reset checks carry no disable, they look at the reset itself
  rst_irq_low_a: assert property (srst_in |=> !phy_irq_out)
    else $error("irq high after reset");
  rst_alt_low_a: assert property (srst_in |=> !alternate_mode_select_out)
    else $error("alternate mode after reset");
  rst_oe_low_a: assert property (srst_in |=> !mgmt_data_oe_out)
    else $error("data driven after reset");
  alt_hold_a: assert property (disable iff (srst_in)
    $fell(srst_in) |-> !alternate_mode_select_out [*8])
    else $error("alternate mode set right after reset");
  oe_mdc_low_a: assert property (disable iff (srst_in)
    $rose(mgmt_data_oe_out) |-> !mgmt_clk_in)
    else $error("drive started while clock high");
  ta_zero_a: assert property (disable iff (srst_in)
    $rose(mgmt_data_oe_out) |-> !mgmt_data_out)
    else $error("turnaround bit not zero");
  oe_span_a: assert property (disable iff (srst_in)
    $rose(mgmt_data_oe_out) |-> mgmt_data_oe_out [*8])
    else $error("read drive too short");
  acc_pulse_a: assert property (disable iff (srst_in)
    ext_acc_out.rd || ext_acc_out.wr |=> !ext_acc_out.rd && !ext_acc_out.wr)
    else $error("access strobe longer than one cycle");
  acc_owned_a: assert property (disable iff (srst_in)
    ext_acc_out.rd |-> ext_acc_out.addr != pim_pkg::REG_EVENT_FLAG)
    else $error("flag register passed outside");
  alt_read_keep_a: assert property (disable iff (srst_in)
    alternate_mode_select_out && mgmt_data_oe_out |-> !$fell(phy_irq_out))
    else $error("read cleared irq in alternate mode");
  alt_on_write_a: assert property (disable iff (srst_in)
    $rose(alternate_mode_select_out) |-> !mgmt_data_oe_out)
    else $error("alternate mode set during read");
  cover property ($rose(alternate_mode_select_out));
  cover property ($rose(phy_irq_out));
  cover property ($rose(mgmt_data_oe_out));
  cover property (ext_acc_out.rd);
endmodule
bind pim_top pim_top_checker #(
  .ENERGY_DELAY_CYCLES(ENERGY_DELAY_CYCLES),
  .ENERGY_HOLD_CYCLES(ENERGY_HOLD_CYCLES)
) i_chk (.sys_clk_in, .srst_in, .mgmt_clk_in, .mgmt_data_out,
  .mgmt_data_oe_out, .ext_acc_out, .alternate_mode_select_out,
  .phy_irq_out);
`default_nettype wire

// ---- bench/pim_mgr.sv ----
// management controller model issuing framed register accesses
`timescale 1ns/100ps
`default_nettype none
module pim_mgr (
  input wire logic clk_in,
  input wire logic md_in,
  input wire logic [4:0] phy_in,
  output logic mdc_out,
  output logic md_en_out,
  output logic md_out,
  output logic vld_out,
  output logic [15:0] rd_out
);
  initial begin
    mdc_out = 1'b0;
    md_en_out = 1'b0;
    md_out = 1'b1;
    vld_out = 1'b0;
    rd_out = 16'h0000;
  end
  // 16 sys clocks a bit, slow enough for the pin filter
  task automatic send(input logic b);
    md_out = b;
    repeat (8) @(negedge clk_in);
    mdc_out = 1'b1;
    rd_out = {rd_out[14:0], md_in};
    repeat (8) @(negedge clk_in);
    mdc_out = 1'b0;
  endtask
  // clock stands low between frames, line released to pull-up
  task automatic frame(input logic wr, input logic [4:0] ra,
      input logic [15:0] wd);
    logic [31:0] s;
    s = {2'b01, wr ? 2'b01 : 2'b10, phy_in, ra, 2'b10, wd};
    md_en_out = 1'b1;
    repeat (32) send(1'b1);
    for (int i = 31; i >= 0; i--) begin
      md_en_out = wr || i > 17;
      send(s[i]);
    end
    md_en_out = 1'b0;
    md_out = 1'b1;
    vld_out = !wr;
    @(negedge clk_in);
    vld_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/pim_top_bench.sv ----
// self-checking bench for the phy interrupt manager
`timescale 1ns/100ps
`default_nettype none
module pim_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:1] s = 9'h040;
  logic [7:0] wk_on = 8'h11, wk_off = 8'h0f;
  logic [4:0] phy = 5'h00;
  logic [15:0] rdat = 16'h0000, rd_data;
  logic ar = 1'b0, hit = 1'b1;
  logic mdc, m_en, m_do, dout, oe, vld, alt, irq_w;
  pim_pkg::pim_acc_t acc;
  wire logic md;
  int errors = 0;
  int n_tests = 0;
  int ids [8] = '{9, 8, 7, 6, 5, 3, 2, 1};
  int al [2] = '{6, 4};
  logic [15:0] exp_q [$];
  assign md = oe ? dout : (m_en ? m_do : 1'b1);
  always #20 clk = ~clk;
  pim_top #(.ENERGY_DELAY_CYCLES(50), .ENERGY_HOLD_CYCLES(20)) i_dut (
    .sys_clk_in(clk), .srst_in(rst), .mgmt_clk_in(mdc),
    .mgmt_data_in(md), .mgmt_data_out(dout), .mgmt_data_oe_out(oe),
    .phy_addr_in(phy), .internal_link_state_in(s[9]),
    .wakeup_control_status_in(s[8] ? wk_on : wk_off),
    .line_energy_present_in(s[7]), .an_complete_in(s[6]),
    .remote_fault_in(s[5]), .link_status_in(!s[4]),
    .partner_ack_in(s[3]), .par_detect_fault_in(s[2]),
    .page_received_in(s[1]), .an_restart_in(ar), .ext_hit_in(hit),
    .ext_rdata_in(rdat), .ext_acc_out(acc),
    .alternate_mode_select_out(alt), .phy_irq_out(irq_w));
  pim_mgr i_mgr (.clk_in(clk), .md_in(md), .phy_in(phy), .mdc_out(mdc),
    .md_en_out(m_en), .md_out(m_do), .vld_out(vld), .rd_out(rd_data));
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic irq(input logic e);
    chk1("irq", e, irq_w);
  endtask
  // wake inputs re-drawn each time, never overlapping while inactive
  task automatic src(input int i, input logic v);
    @(negedge clk);
    wk_on = 8'h11 << ($urandom % 4);
    wk_off = ($urandom % 2) ? 8'hf0 : 8'h0f;
    s[i] = v;
    repeat (3) @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_mgr.frame(1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_mgr.frame(1'b1, a, d);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge vld) chk16("read data", exp_q.pop_front(), rd_data);
  initial begin
    #3000000;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    void'($urandom(16));
    phy = 5'($urandom);
    rdat = 16'($urandom);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    irq(1'b0);
    rd(5'h1d, 16'h0080);
    rd(5'h1d, 16'h0000);
    rd(5'h1e, 16'h0000);
    rd(5'h11, 16'h0002);
    src(7, 1'b0);
    $display("test 1 done");
    wr(5'h1e, 16'h03fe);
    foreach (ids[j]) begin
      src(ids[j], 1'b1);
      irq(1'b1);
      src(ids[j], 1'b0);
      irq(1'b0);
    end
    src(4, 1'b1);
    irq(1'b1);
    src(4, 1'b0);
    irq(1'b1);
    rd(5'h01, rdat);
    chk16("acc addr", 16'h0001, 16'(acc.addr));
    irq(1'b0);
    $display("test 2 done");
    src(5, 1'b1);
    rd(5'h01, rdat);
    irq(1'b0);
    src(5, 1'b0);
    src(2, 1'b1);
    rd(5'h06, rdat);
    irq(1'b0);
    src(2, 1'b0);
    src(1, 1'b1);
    ar = 1'b1;
    @(negedge clk);
    ar = 1'b0;
    repeat (2) @(negedge clk);
    irq(1'b0);
    src(1, 1'b0);
    src(2, 1'b1);
    src(4, 1'b1);
    rd(5'h1d, 16'h0010);
    src(4, 1'b0);
    src(2, 1'b0);
    src(9, 1'b1);
    rd(5'h1d, 16'h0200);
    irq(1'b0);
    src(9, 1'b0);
    wr(5'h1e, 16'h0100);
    src(6, 1'b1);
    irq(1'b0);
    src(8, 1'b1);
    irq(1'b1);
    src(8, 1'b0);
    irq(1'b0);
    rd(5'h1d, 16'h0040);
    src(6, 1'b0);
    $display("test 3 done");
    wr(5'h1e, 16'h0080);
    src(7, 1'b1);
    irq(1'b1);
    rd(5'h1d, 16'h0080);
    irq(1'b0);
    src(7, 1'b0);
    repeat (27) @(negedge clk);
    irq(1'b0);
    repeat (30) @(negedge clk);
    irq(1'b1);
    repeat (30) @(negedge clk);
    irq(1'b0);
    wr(5'h1e, 16'h0000);
    $display("test 4 done");
    wr(5'h11, 16'h0040);
    chk1("alt mode", 1'b1, alt);
    rd(5'h11, 16'h0040);
    wr(5'h1e, 16'h03fe);
    foreach (al[j]) begin
      src(al[j], 1'b1);
      rd(5'h1d, 16'(1 << al[j]));
      irq(1'b1);
      wr(5'h1d, 16'(1 << al[j]));
      irq(1'b1);
      src(al[j], 1'b0);
      irq(1'b1);
      wr(5'h1d, 16'(1 << al[j]));
      irq(1'b0);
    end
    $display("test 5 done");
    hit = 1'b0;
    rd(5'h02, 16'hffff);
    wr(5'h02, rdat);
    chk16("acc wdata", rdat, acc.wdata);
    hit = 1'b1;
    $display("test 6 done");
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk1("alt mode", 1'b0, alt);
    irq(1'b0);
    rd(5'h11, 16'h0000);
    $display("test 7 done");
    print_verdict();
  end
endmodule
`default_nettype wire
